// >>> hdl/sso_regs.svh
/*
  Constants of the servo status output block: widths, reset
  values and timing counts. Assumes a 250 MHz system clock.
*/
`ifndef SSO_REGS_SVH
`define SSO_REGS_SVH

// ==========================================================
// Clock
`define SSO_CLK_MHZ 250
`define SSO_CLK_NS 4

// ==========================================================
// Absolute serial frame
`define SSO_ABS_BIT_NS 1000
`define SSO_ABS_BIT_CYC ((`SSO_ABS_BIT_NS * `SSO_CLK_MHZ) / 1000)
`define SSO_ABS_DATA_BITS 24
`define SSO_ABS_IDLE_LEVEL 1'b1

// ==========================================================
// Widths and reset values
`define SSO_SPEED_W 16
`define SSO_ERR_W 20
`define SSO_GEAR_W 16
`define SSO_CODE_NONE 3'h0
`define SSO_SEL_W 3

`endif

// >>> hdl/sso_pkg.sv
/*
  Types of the servo status output block.
  Assumes sso_regs.svh is compiled alongside.
*/
`default_nettype none
package sso_pkg;

  typedef enum logic {
    SSO_MODE_SPEED = 1'b0,
    SSO_MODE_POS = 1'b1
  } sso_mode_t;

  // Functions that a status output may carry
  typedef enum logic [2:0] {
    SSO_FN_ROTATE = 3'h0,
    SSO_FN_READY = 3'h1,
    SSO_FN_MATCH_DONE = 3'h2,
    SSO_FN_CUR_LIMIT = 3'h3,
    SSO_FN_SPD_LIMIT = 3'h4,
    SSO_FN_BRAKE = 3'h5,
    SSO_FN_WARN = 3'h6,
    SSO_FN_POSITION_OUT_A = 3'h7
  } sso_fn_t;

  typedef enum logic [3:0] {
    SSO_SER_IDLE = 4'b0001,
    SSO_SER_START = 4'b0010,
    SSO_SER_DATA = 4'b0100,
    SSO_SER_STOP = 4'b1000
  } sso_ser_t;

endpackage : sso_pkg

`default_nettype wire

// >>> hdl/sso_quad_gen.sv
/*
  Quadrature generator: one encoder step per enable moves a 2-bit binary
  count, decoded into gray A/B phases; the index input gives the origin pulse.
  Assumes step, dir and index come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sso_quad_gen (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic step,
  input wire logic dir,
  input wire logic index,
  output logic phase_a,
  output logic phase_b,
  output logic phase_c
);

  logic [1:0] count;

  // ==========================================================
  // Gray sequence 00-01-11-10 keeps exactly one phase changing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 2'h0;
    end else if (step) begin
      count <= dir ? count + 2'h1 : count - 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      phase_c <= 1'b0;
    end else begin
      phase_a <= count[1];
      phase_b <= count[1] ^ count[0];
      phase_c <= index;
    end
  end

  property p_one_phase;
    @(posedge clock) disable iff (!rst_b)
      (phase_a != $past(phase_a)) |-> (phase_b == $past(phase_b));
  endproperty
  a_one_phase: assert property (p_one_phase) else $error("both phases changed at once");

endmodule : sso_quad_gen

`default_nettype wire

// >>> hdl/sso_status_out.sv
/*
  Servo status output logic: fault, fault code, ready, rotation detect,
  shared speed-match / positioning-done, assignable outputs, encoder
  pulse re-emission and absolute serial data.
  Assumes host pins arrive asynchronously and all other inputs come
  from logic on the same 250 MHz clock.
*/
// Overview of operation
// - Fault output high only while no fault; drops on any fault.
// - Rotation detect high while speed magnitude exceeds programmed threshold.
// - Ready high only with main power on and no fault.
// - Encoder steps become A/B quadrature plus origin pulse, with complements.
// - Absolute position sent as serial frame on differential pair.
// - Latched fault shown as binary code on three code outputs.
// - Speed mode: match high while speed within band of reference.
// - Position mode: done high when error count within completion width.
// - Error count kept in reference units through the electronic gear.
// - One shared output carries match or done, chosen by mode.
// - Each assignable output's function (rotation detect, ready, match/done) chosen by a selector input.
// - Host fault reset clears fault indication and fault code.
// - Host clear input zeroes the position error count, in position mode only.
`timescale 1ns/1ps
`default_nettype none
`include "sso_regs.svh"

module sso_status_out (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic init_done,
  input wire logic main_power_on,
  input wire logic [2:0] fault_req_code,
  input wire logic fault_reset_in,
  input wire logic error_counter_clear_in,
  input wire logic cmd_pulse_in,
  input wire logic cmd_dir_in,
  input wire sso_pkg::sso_mode_t ctrl_mode,
  input wire logic signed [`SSO_SPEED_W-1:0] motor_speed,
  input wire logic signed [`SSO_SPEED_W-1:0] speed_ref,
  input wire logic [`SSO_SPEED_W-1:0] rotate_level,
  input wire logic [`SSO_SPEED_W-1:0] match_band,
  input wire logic [`SSO_ERR_W-1:0] done_width,
  input wire logic [`SSO_ERR_W-1:0] position_out_a_width,
  input wire logic [`SSO_GEAR_W-1:0] gear_num,
  input wire logic [`SSO_GEAR_W-1:0] gear_den,
  input wire logic enc_step,
  input wire logic enc_dir,
  input wire logic enc_index,
  input wire logic abs_fitted,
  input wire logic abs_load,
  input wire logic [`SSO_ABS_DATA_BITS-1:0] abs_position,
  input wire logic cur_limit_in,
  input wire logic spd_limit_in,
  input wire logic brake_in,
  input wire logic warn_in,
  input wire sso_pkg::sso_fn_t sel_out0,
  input wire sso_pkg::sso_fn_t sel_out1,
  input wire sso_pkg::sso_fn_t sel_out2,
  output logic servo_fault_out,
  output logic fault_code_bit0,
  output logic fault_code_bit1,
  output logic fault_code_bit2,
  output logic rotation_detect_out,
  output logic servo_ready_out,
  output logic match_done_out,
  output logic quad_a_out,
  output logic quad_a_out_n,
  output logic quad_b_out,
  output logic quad_b_out_n,
  output logic origin_pulse_out,
  output logic origin_pulse_out_n,
  output logic abs_serial_out,
  output logic abs_serial_out_n
);

  localparam int ABS_CYC = `SSO_ABS_BIT_CYC;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] rst_sync;
  logic [1:0] clr_sync;
  logic [1:0] pul_sync;
  logic [1:0] dir_sync;
  logic pul_prev;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
      clr_sync <= 2'h0;
      pul_sync <= 2'h0;
      dir_sync <= 2'h0;
      pul_prev <= 1'b0;
    end else begin
      rst_sync <= {rst_sync[0], fault_reset_in};
      clr_sync <= {clr_sync[0], error_counter_clear_in};
      pul_sync <= {pul_sync[0], cmd_pulse_in};
      dir_sync <= {dir_sync[0], cmd_dir_in};
      pul_prev <= pul_sync[1];
    end
  end

  // ==========================================================
  // Fault latch
  logic [2:0] fault_code;
  wire fault_active = (fault_code != `SSO_CODE_NONE);
  wire fault_new = (fault_req_code != `SSO_CODE_NONE);

  // A fault present in the reset cycle wins over the reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault_code <= `SSO_CODE_NONE;
    end else if (fault_new && (!fault_active || rst_sync[1])) begin
      fault_code <= fault_req_code;
    end else if (rst_sync[1]) begin
      fault_code <= `SSO_CODE_NONE;
    end
  end

  // ==========================================================
  // Position error counter in reference units
  logic signed [`SSO_ERR_W-1:0] err_count;
  logic [`SSO_GEAR_W:0] gear_acc;
  logic [`SSO_GEAR_W:0] gear_sum;
  logic gear_wrap;
  logic signed [`SSO_ERR_W-1:0] err_delta;

  always_comb begin
    gear_sum = gear_acc + {1'b0, gear_den};
    gear_wrap = enc_step && (gear_sum >= {1'b0, gear_num});
    err_delta = '0;
    if (pul_sync[1] && !pul_prev) begin
      err_delta = dir_sync[1] ? `SSO_ERR_W'sd1 : -`SSO_ERR_W'sd1;
    end
    if (gear_wrap) begin
      err_delta = err_delta - (enc_dir ? `SSO_ERR_W'sd1 : -`SSO_ERR_W'sd1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_count <= '0;
      gear_acc <= '0;
    end else if (clr_sync[1] && ctrl_mode == sso_pkg::SSO_MODE_POS) begin
      err_count <= '0;
      gear_acc <= '0;
    end else begin
      err_count <= err_count + err_delta;
      if (gear_wrap) begin
        gear_acc <= gear_sum - {1'b0, gear_num};
      end else if (enc_step) begin
        gear_acc <= gear_sum;
      end
    end
  end

  // ==========================================================
  // Status conditions
  function automatic logic [`SSO_ERR_W-1:0] sso_abs_err(
    input logic signed [`SSO_ERR_W-1:0] v);
    sso_abs_err = v[`SSO_ERR_W-1] ? `SSO_ERR_W'(-v) : `SSO_ERR_W'(v);
  endfunction : sso_abs_err

  logic [`SSO_SPEED_W:0] speed_mag;
  logic [`SSO_SPEED_W:0] speed_diff;
  logic signed [`SSO_SPEED_W:0] speed_sub;
  logic rotating;
  logic speed_match;
  logic pos_done;
  logic pos_position_out_a;
  logic match_done;

  always_comb begin
    speed_mag = motor_speed[`SSO_SPEED_W-1] ? (`SSO_SPEED_W+1)'(-motor_speed)
                                           : (`SSO_SPEED_W+1)'(motor_speed);
    speed_sub = (`SSO_SPEED_W+1)'(motor_speed) - (`SSO_SPEED_W+1)'(speed_ref);
    speed_diff = speed_sub[`SSO_SPEED_W] ? (`SSO_SPEED_W+1)'(-speed_sub)
                                         : (`SSO_SPEED_W+1)'(speed_sub);
    rotating = speed_mag > {1'b0, rotate_level};
    speed_match = speed_diff <= {1'b0, match_band};
    pos_done = sso_abs_err(err_count) <= done_width;
    pos_position_out_a = sso_abs_err(err_count) <= position_out_a_width;
    match_done = (ctrl_mode == sso_pkg::SSO_MODE_POS) ? pos_done : speed_match;
  end

  wire ready_cond = main_power_on && !fault_active;

  // Shared decode for the three assignable outputs
  function automatic logic sso_pick(input sso_pkg::sso_fn_t sel, input logic [7:0] fns);
    sso_pick = fns[sel];
  endfunction : sso_pick

  logic [7:0] fn_vec;
  assign fn_vec = {pos_position_out_a, warn_in, brake_in, spd_limit_in, cur_limit_in,
                   match_done, ready_cond, rotating};

  // ==========================================================
  // Status outputs, held off until initialised
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      servo_fault_out <= 1'b0;
      fault_code_bit0 <= 1'b0;
      fault_code_bit1 <= 1'b0;
      fault_code_bit2 <= 1'b0;
      rotation_detect_out <= 1'b0;
      servo_ready_out <= 1'b0;
      match_done_out <= 1'b0;
    end else if (!init_done) begin
      servo_fault_out <= 1'b0;
      fault_code_bit0 <= 1'b0;
      fault_code_bit1 <= 1'b0;
      fault_code_bit2 <= 1'b0;
      rotation_detect_out <= 1'b0;
      servo_ready_out <= 1'b0;
      match_done_out <= 1'b0;
    end else begin
      servo_fault_out <= !fault_active;
      fault_code_bit0 <= fault_code[0];
      fault_code_bit1 <= fault_code[1];
      fault_code_bit2 <= fault_code[2];
      rotation_detect_out <= sso_pick(sel_out0, fn_vec);
      servo_ready_out <= sso_pick(sel_out1, fn_vec);
      match_done_out <= sso_pick(sel_out2, fn_vec);
    end
  end

  // ==========================================================
  // Encoder pulse output
  logic qa;
  logic qb;
  logic qc;

  sso_quad_gen u_quad (
    .clock(clock),
    .rst_b(rst_b),
    .step(enc_step),
    .dir(enc_dir),
    .index(enc_index),
    .phase_a(qa),
    .phase_b(qb),
    .phase_c(qc)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      quad_a_out <= 1'b0;
      quad_a_out_n <= 1'b1;
      quad_b_out <= 1'b0;
      quad_b_out_n <= 1'b1;
      origin_pulse_out <= 1'b0;
      origin_pulse_out_n <= 1'b1;
    end else begin
      quad_a_out <= qa;
      quad_a_out_n <= !qa;
      quad_b_out <= qb;
      quad_b_out_n <= !qb;
      origin_pulse_out <= qc;
      origin_pulse_out_n <= !qc;
    end
  end

  // ==========================================================
  // Absolute serial frame: start 0, data LSB first, stop 1
  sso_pkg::sso_ser_t ser_state;
  logic [`SSO_ABS_DATA_BITS-1:0] ser_shift;
  logic [4:0] ser_bits;
  logic [8:0] bit_timer;
  wire bit_tick = (bit_timer == 9'(ABS_CYC - 1));

  // Timer restarts with each frame so every bit is full length
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_timer <= 9'h000;
    end else if (ser_state == sso_pkg::SSO_SER_IDLE || bit_tick) begin
      bit_timer <= 9'h000;
    end else begin
      bit_timer <= bit_timer + 9'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ser_state <= sso_pkg::SSO_SER_IDLE;
      ser_shift <= '0;
      ser_bits <= 5'h00;
    end else begin
      unique case (ser_state)
        sso_pkg::SSO_SER_IDLE: begin
          if (abs_load && abs_fitted) begin
            ser_shift <= abs_position;
            ser_state <= sso_pkg::SSO_SER_START;
          end
        end
        sso_pkg::SSO_SER_START: begin
          if (bit_tick) begin
            ser_bits <= 5'h00;
            ser_state <= sso_pkg::SSO_SER_DATA;
          end
        end
        sso_pkg::SSO_SER_DATA: begin
          if (bit_tick) begin
            ser_shift <= ser_shift >> 1;
            ser_bits <= ser_bits + 5'h01;
            if (ser_bits == 5'(`SSO_ABS_DATA_BITS - 1)) begin
              ser_state <= sso_pkg::SSO_SER_STOP;
            end
          end
        end
        sso_pkg::SSO_SER_STOP: begin
          if (bit_tick) begin
            ser_state <= sso_pkg::SSO_SER_IDLE;
          end
        end
        default: ser_state <= sso_pkg::SSO_SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      abs_serial_out <= `SSO_ABS_IDLE_LEVEL;
      abs_serial_out_n <= !`SSO_ABS_IDLE_LEVEL;
    end else begin
      abs_serial_out <= (ser_state == sso_pkg::SSO_SER_START) ? 1'b0 :
                        (ser_state == sso_pkg::SSO_SER_DATA) ? ser_shift[0] : 1'b1;
      abs_serial_out_n <= (ser_state == sso_pkg::SSO_SER_START) ? 1'b1 :
                          (ser_state == sso_pkg::SSO_SER_DATA) ? !ser_shift[0] : 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_fault_seen;
    init_done && fault_new;
  endsequence

  property p_fault_drop;
    @(posedge clock) disable iff (!rst_b) s_fault_seen ##1 init_done |=> !servo_fault_out;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("fault output stayed on");

  property p_rotate;
    @(posedge clock) disable iff (!rst_b)
      init_done && sel_out0 == sso_pkg::SSO_FN_ROTATE |=> rotation_detect_out == $past(rotating);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation detect wrong");

  property p_ready;
    @(posedge clock) disable iff (!rst_b)
      $past(sel_out1) == sso_pkg::SSO_FN_READY && $past(init_done)
      |-> servo_ready_out == $past(ready_cond);
  endproperty
  a_ready: assert property (p_ready) else $error("ready output wrong");

  property p_quad_comp;
    @(posedge clock) disable iff (!rst_b) quad_a_out != quad_a_out_n && quad_b_out != quad_b_out_n;
  endproperty
  a_quad_comp: assert property (p_quad_comp) else $error("quadrature pair not complementary");

  property p_serial_start;
    @(posedge clock) disable iff (!rst_b)
      ser_state == sso_pkg::SSO_SER_IDLE && abs_load && abs_fitted |-> ##2 !abs_serial_out;
  endproperty
  a_serial_start: assert property (p_serial_start) else $error("no start bit");

  property p_code_hold;
    @(posedge clock) disable iff (!rst_b)
      fault_active && !rst_sync[1] |=> fault_code == $past(fault_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("fault code changed");

  property p_clear;
    @(posedge clock) disable iff (!rst_b)
      clr_sync[1] && ctrl_mode == sso_pkg::SSO_MODE_POS |=> err_count == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("error count not cleared");

  property p_init_hold;
    @(posedge clock) disable iff (!rst_b)
      !init_done [*2] |-> !servo_ready_out && !match_done_out && !servo_fault_out;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("output active before init");

  property p_reset_clears;
    @(posedge clock) disable iff (!rst_b) rst_sync[1] && !fault_new |=> !fault_active;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("fault not released");

endmodule : sso_status_out

`default_nettype wire

// >>> tb/sso_host_model.sv
/*
  Host controller model: counts quadrature steps, receives the absolute
  serial frame and drives the host pins (fault reset, clear, commands).
  Assumes the block's clock and its serial bit time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sso_regs.svh"

module sso_host_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic ser_in,
  output var logic fault_reset,
  output var logic cnt_clear,
  output var logic cmd_pulse,
  output var logic cmd_dir
);
  int quad_count;
  logic [1:0] phase_prev;
  // Gray phase turned into a 0..3 position so a step is a difference
  wire logic [1:0] phase_now = {quad_a, quad_a ^ quad_b};
  wire logic [1:0] phase_step = phase_now - phase_prev;

  initial begin
    fault_reset = 1'b0;
    cnt_clear = 1'b0;
    cmd_pulse = 1'b0;
    cmd_dir = 1'b0;
  end

  // ==========================================================
  // Quadrature counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_prev <= 2'h0;
      quad_count <= 0;
    end else begin
      phase_prev <= phase_now;
      if (phase_step == 2'h1)
        quad_count <= quad_count + 1;
      else if (phase_step == 2'h3)
        quad_count <= quad_count - 1;
    end
  end

  // ==========================================================
  // Host pins, held long enough to pass the pin synchronisers
  task automatic pulse_reset();
    @(posedge clock);
    fault_reset <= 1'b1;
    repeat (4) @(posedge clock);
    fault_reset <= 1'b0;
  endtask : pulse_reset

  task automatic pulse_clear();
    @(posedge clock);
    cnt_clear <= 1'b1;
    repeat (4) @(posedge clock);
    cnt_clear <= 1'b0;
  endtask : pulse_clear

  task automatic send_cmd(input logic dir, input int n);
    @(posedge clock);
    cmd_dir <= dir;
    repeat (n) begin
      repeat (4) @(posedge clock);
      cmd_pulse <= 1'b1;
      repeat (4) @(posedge clock);
      cmd_pulse <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask : send_cmd

  // ==========================================================
  // Serial receiver, sampling mid-bit
  task automatic rx_frame(output logic [`SSO_ABS_DATA_BITS-1:0] word, output logic ok);
    int wait_cnt;
    wait_cnt = 0;
    ok = 1'b0;
    word = '0;
    while (ser_in !== 1'b0 && wait_cnt < 20) begin
      @(posedge clock);
      wait_cnt++;
    end
    if (ser_in === 1'b0) begin
      repeat (`SSO_ABS_BIT_CYC / 2) @(posedge clock);
      ok = (ser_in === 1'b0);
      for (int i = 0; i < `SSO_ABS_DATA_BITS; i++) begin
        repeat (`SSO_ABS_BIT_CYC) @(posedge clock);
        word[i] = ser_in;
      end
      repeat (`SSO_ABS_BIT_CYC) @(posedge clock);
      ok = ok && (ser_in === 1'b1);
    end
  endtask : rx_frame
endmodule : sso_host_model
`default_nettype wire

// >>> tb/sso_status_out_test.sv
/*
  Self-checking bench of the servo status output block.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sso_regs.svh"

module sso_status_out_test;
  logic clock, rst_b, init_done, main_power_on, enc_step, enc_dir, enc_index;
  logic abs_fitted, abs_load, cur_limit_in, spd_limit_in, brake_in, warn_in;
  logic [2:0] fault_req_code;
  sso_pkg::sso_mode_t ctrl_mode;
  sso_pkg::sso_fn_t sel_out0, sel_out1, sel_out2;
  logic signed [`SSO_SPEED_W-1:0] motor_speed, speed_ref;
  logic [`SSO_SPEED_W-1:0] rotate_level, match_band;
  logic [`SSO_ERR_W-1:0] done_width, position_out_a_width;
  logic [`SSO_GEAR_W-1:0] gear_num, gear_den;
  logic [`SSO_ABS_DATA_BITS-1:0] abs_position;
  wire logic fault_reset_in, error_counter_clear_in, cmd_pulse_in, cmd_dir_in;
  logic servo_fault_out, fault_code_bit0, fault_code_bit1, fault_code_bit2;
  logic rotation_detect_out, servo_ready_out, match_done_out;
  logic quad_a_out, quad_a_out_n, quad_b_out, quad_b_out_n;
  logic origin_pulse_out, origin_pulse_out_n, abs_serial_out, abs_serial_out_n;
  int error_cnt = 0;
  int compares = 0;

  sso_status_out DUT (.clock, .rst_b, .init_done, .main_power_on, .fault_req_code,
    .fault_reset_in, .error_counter_clear_in, .cmd_pulse_in, .cmd_dir_in, .ctrl_mode,
    .motor_speed, .speed_ref, .rotate_level, .match_band, .done_width, .position_out_a_width,
    .gear_num, .gear_den, .enc_step, .enc_dir, .enc_index, .abs_fitted, .abs_load,
    .abs_position, .cur_limit_in, .spd_limit_in, .brake_in, .warn_in, .sel_out0,
    .sel_out1, .sel_out2, .servo_fault_out, .fault_code_bit0, .fault_code_bit1,
    .fault_code_bit2, .rotation_detect_out, .servo_ready_out, .match_done_out,
    .quad_a_out, .quad_a_out_n, .quad_b_out, .quad_b_out_n, .origin_pulse_out,
    .origin_pulse_out_n, .abs_serial_out, .abs_serial_out_n);

  sso_host_model host (.clock, .rst_b, .quad_a(quad_a_out), .quad_b(quad_b_out),
    .ser_in(abs_serial_out), .fault_reset(fault_reset_in),
    .cnt_clear(error_counter_clear_in), .cmd_pulse(cmd_pulse_in), .cmd_dir(cmd_dir_in));

  // ==========================================================
  // Helpers
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic enc_pulses(input logic dir, input int n);
    repeat (n) begin
      @(posedge clock);
      enc_dir <= dir;
      enc_step <= 1'b1;
      @(posedge clock);
      enc_step <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : enc_pulses

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  task automatic t_init();
    tick(4);
    check({quad_a_out, quad_a_out_n, abs_serial_out, abs_serial_out_n}, 4'h6, "reset lvl");
    @(posedge clock);
    rst_b <= 1'b1;
    tick(10);
    check({servo_fault_out, servo_ready_out, rotation_detect_out}, 3'h0, "pre init");
    check(match_done_out, 1'b0, "match pre init");
    @(posedge clock);
    init_done <= 1'b1;
    tick(6);
    check({servo_fault_out, servo_ready_out, rotation_detect_out}, 3'h7, "post init");
    $display("test init done");
  endtask : t_init

  task automatic t_fault();
    @(posedge clock);
    fault_req_code <= 3'h5;
    tick(6);
    check({servo_fault_out, servo_ready_out}, 2'h0, "fault out");
    check({fault_code_bit2, fault_code_bit1, fault_code_bit0}, 3'h5, "code");
    @(posedge clock);
    fault_req_code <= 3'h3;
    tick(6);
    check({fault_code_bit2, fault_code_bit1, fault_code_bit0}, 3'h5, "code held");
    @(posedge clock);
    fault_req_code <= `SSO_CODE_NONE;
    tick(6);
    check(servo_fault_out, 1'b0, "fault latched");
    host.pulse_reset();
    tick(6);
    check({servo_fault_out, servo_ready_out}, 2'h3, "fault cleared");
    check({fault_code_bit2, fault_code_bit1, fault_code_bit0}, 3'h0, "code cleared");
    @(posedge clock);
    main_power_on <= 1'b0;
    tick(6);
    check({servo_fault_out, servo_ready_out}, 2'h2, "no power");
    @(posedge clock);
    main_power_on <= 1'b1;
    tick(6);
    check(servo_ready_out, 1'b1, "power back");
    $display("test fault done");
  endtask : t_fault

  task automatic t_speed();
    int spd[4] = '{100, 101, -101, -100};
    int mt[4] = '{210, 211, 190, 189};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      motor_speed <= `SSO_SPEED_W'(spd[i]);
      tick(6);
      check(rotation_detect_out, (4'h6 >> i) & 4'h1, "rotate");
    end
    @(posedge clock);
    speed_ref <= `SSO_SPEED_W'(200);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      motor_speed <= `SSO_SPEED_W'(mt[i]);
      tick(6);
      check(match_done_out, (4'h5 >> i) & 4'h1, "match");
    end
    $display("test speed done");
  endtask : t_speed

  task automatic t_quad();
    int base;
    base = host.quad_count;
    enc_pulses(1'b1, 6);
    enc_pulses(1'b0, 2);
    tick(6);
    check(24'(host.quad_count - base), 24'h4, "quad count");
    check({quad_a_out ^ quad_a_out_n, quad_b_out ^ quad_b_out_n}, 2'h3, "quad n");
    @(posedge clock);
    enc_index <= 1'b1;
    tick(4);
    check({origin_pulse_out, origin_pulse_out_n}, 2'h2, "origin on");
    @(posedge clock);
    enc_index <= 1'b0;
    tick(6);
    check({origin_pulse_out, origin_pulse_out_n}, 2'h1, "origin off");
    $display("test quad done");
  endtask : t_quad

  task automatic t_done();
    @(posedge clock);
    ctrl_mode <= sso_pkg::SSO_MODE_POS;
    gear_num <= `SSO_GEAR_W'(2);
    gear_den <= `SSO_GEAR_W'(1);
    host.pulse_clear();
    tick(6);
    check(match_done_out, 1'b1, "done zero err");
    host.send_cmd(1'b1, 3);
    tick(6);
    check(match_done_out, 1'b0, "err 3");
    enc_pulses(1'b1, 2);
    tick(6);
    check(match_done_out, 1'b0, "err 2 after gear");
    enc_pulses(1'b1, 2);
    tick(6);
    check(match_done_out, 1'b1, "err 1 within");
    host.send_cmd(1'b1, 5);
    @(posedge clock);
    ctrl_mode <= sso_pkg::SSO_MODE_SPEED;
    motor_speed <= `SSO_SPEED_W'(200);
    tick(6);
    check(match_done_out, 1'b1, "shared pin speed");
    @(posedge clock);
    ctrl_mode <= sso_pkg::SSO_MODE_POS;
    tick(6);
    check(match_done_out, 1'b0, "shared pin pos");
    host.pulse_clear();
    tick(6);
    check(match_done_out, 1'b1, "cleared");
    $display("test done done");
  endtask : t_done

  task automatic t_assign();
    @(posedge clock);
    motor_speed <= `SSO_SPEED_W'(300);
    sel_out1 <= sso_pkg::SSO_FN_WARN;
    sel_out2 <= sso_pkg::SSO_FN_CUR_LIMIT;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      sel_out0 <= sso_pkg::sso_fn_t'(i[2:0]);
      tick(6);
      check(rotation_detect_out, (8'hD7 >> i) & 8'h1, "assign");
    end
    check({servo_ready_out, match_done_out}, 2'h2, "assign others");
    @(posedge clock);
    sel_out0 <= sso_pkg::SSO_FN_ROTATE;
    $display("test assign done");
  endtask : t_assign

  task automatic t_serial();
    logic [`SSO_ABS_DATA_BITS-1:0] word;
    logic ok;
    check({abs_serial_out, abs_serial_out_n}, 2'h2, "serial idle");
    @(posedge clock);
    {abs_fitted, abs_load} <= 2'h1;
    tick(4);
    check({abs_serial_out, abs_serial_out_n}, 2'h2, "no frame unfitted");
    @(posedge clock);
    {abs_fitted, abs_load} <= 2'h2;
    fork
      host.rx_frame(word, ok);
      begin
        @(posedge clock);
        abs_load <= 1'b1;
        @(posedge clock);
        abs_load <= 1'b0;
      end
    join
    check(word, abs_position, "serial data");
    check(ok, 1'b1, "serial framing");
    $display("test serial done");
  endtask : t_serial

  // ==========================================================
  // Clock, stimulus and watchdog
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    rst_b = 1'b0;
    {init_done, enc_step, enc_dir, enc_index, abs_load} = '0;
    {cur_limit_in, brake_in} = 2'h0;
    {spd_limit_in, warn_in, main_power_on, abs_fitted} = 4'hF;
    fault_req_code = `SSO_CODE_NONE;
    ctrl_mode = sso_pkg::SSO_MODE_SPEED;
    sel_out0 = sso_pkg::SSO_FN_ROTATE;
    sel_out1 = sso_pkg::SSO_FN_READY;
    sel_out2 = sso_pkg::SSO_FN_MATCH_DONE;
    motor_speed = `SSO_SPEED_W'(300);
    speed_ref = `SSO_SPEED_W'(300);
    rotate_level = `SSO_SPEED_W'(100);
    match_band = `SSO_SPEED_W'(10);
    done_width = `SSO_ERR_W'(1);
    position_out_a_width = `SSO_ERR_W'(4);
    gear_num = `SSO_GEAR_W'(1);
    gear_den = `SSO_GEAR_W'(1);
    abs_position = 24'hA5C396;
    t_init();
    t_fault();
    t_speed();
    t_quad();
    t_done();
    t_assign();
    t_serial();
    end_sim();
  end

  // Whole run is under 7,000 cycles; the 50,000-cycle watchdog leaves a wide margin
  initial begin
    #200000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : sso_status_out_test
`default_nettype wire
